// file: design/bmp_backup_control.sv
/*
  Backup mode protection control: input switch trip, indicator pin functions,
  backup converter enable, shutdown and status, with an I2C register port.
  Assumes analog comparator levels and I2C pins arrive asynchronously and are
  synchronised here; the indicator pin and SDA have external pull-ups.
*/
// How it works
// R1: Secondary overcurrent hit opens the input switch at once and enters backup (reset state here if the allow bit is clear).
// R2: Trip select codes 00..11 give 6.5, 10.5, 14.5 and 18.5 A.
// R3: Indicator function is a 2-bit field in register 0x26, host writable.
// R4: Code 00 pulls the indicator low only while in backup mode.
// R5: Code 01 holds it low until storage regulates, low again below 95 percent.
// R6: Code 11 releases it only with input inside window and not in backup.
// R7: Writes of code 10 to the function field are ignored.
// R8: Converter off without allow bit; forced off at backup entry means reset state.
// R9: Discharge bit turns on the 50 mA sink on bus and storage.
// R10: Output target is 2.5 V plus 100 mV per code, clamped at 13.2 V.
// R11: Storage lockout, output undervoltage or overvoltage stop the converter.
// R12: Undervoltage threshold selects 60 or 70 percent of the setpoint.
// R13: Undervoltage sets not-good status and moves to the reset state.
// R14: Masked undervoltage keeps running, full duty once storage drops below output.
// R15: Overvoltage threshold is fixed at 110 percent of setpoint.
// R16: Current limit code 000 gives 3 A, each step adds 1 A.
// R17: Switch current over its fraction of the limit shuts the converter at once.
// R18: Any protective input switch opening enters backup mode (reset state here if the allow bit is clear).
// R19: Indicator pin is open drain: only pulled low, otherwise undriven.
`timescale 1ns/1ps
`default_nettype none
module bmp_backup_control
  import bmp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary bus address
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic vin_above_low,
  input wire logic vin_below_high,
  input wire logic input_protect_trip,
  input wire logic secondary_oc_hit,
  input wire logic storage_in_reg,
  input wire logic storage_below_95,
  input wire logic storage_above_lockout,
  input wire logic backup_out_below_uv,
  input wire logic backup_out_above_ov,
  input wire logic backup_switch_oc,
  input wire logic storage_below_out,
  output logic input_switch_on,
  output logic backup_converter_en,
  output logic full_duty,
  output logic discharge_sink_on,
  output logic loss_indicator_pin_out,
  output logic loss_indicator_pin_oe,
  output logic [1:0] overcurrent_trip_sel,
  output logic [7:0] oc_trip_level,
  output logic [7:0] vout_target_level,
  output logic [7:0] uv_level,
  output logic [7:0] ov_level,
  output logic [3:0] current_limit_value
);

  // Two-stage synchronisers; only the second stage is read
  logic [12:0] raw;
  logic [12:0] sync1;
  logic [12:0] sync2;
  assign raw = {scl_in, sda_in, vin_above_low, vin_below_high, input_protect_trip,
                secondary_oc_hit, storage_in_reg, storage_below_95, storage_above_lockout,
                backup_out_below_uv, backup_out_above_ov, backup_switch_oc, storage_below_out};
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
    end
  end

  logic scl, sda, vin_low_ok, vin_high_ok, protect, sec_oc, str_reg, str_low95;
  logic str_lock_ok, out_uv, out_ov, sw_oc, str_below_out;
  assign {scl, sda, vin_low_ok, vin_high_ok, protect, sec_oc, str_reg, str_low95,
          str_lock_ok, out_uv, out_ov, sw_oc, str_below_out} = sync2;

  // I2C line edges and bus conditions
  logic scl_prev, sda_prev;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl;
      sda_prev <= sda;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl & ~scl_prev;
  assign scl_fall = ~scl & scl_prev;
  assign bus_start = scl & scl_prev & sda_prev & ~sda;
  assign bus_stop = scl & scl_prev & ~sda_prev & sda;

  // Register file
  logic [1:0] indicator_function_sel;
  logic [6:0] backup_vout_code;
  logic [6:0] ctrl;
  logic backup_not_good;
  logic stopped;
  bmp_state_t state;

  logic backup_converter_allow, discharge_enable, backup_uv_sel, backup_not_good_mask;
  logic [2:0] backup_current_limit_code;
  assign backup_converter_allow = ctrl[CTRL_ALLOW];
  assign discharge_enable = ctrl[CTRL_DISC];
  assign backup_uv_sel = ctrl[CTRL_UV70];
  assign backup_not_good_mask = ctrl[CTRL_MASK];
  assign backup_current_limit_code = ctrl[CTRL_CLIM_LSB +: 3];

  // I2C slave byte engine
  bmp_i2c_t phase;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txb;
  logic [7:0] ptr;
  logic [7:0] rd_data;
  logic byte_done, wr_en, addr_hit;
  assign byte_done = scl_fall & (bit_cnt == BYTE_BITS);
  assign wr_en = byte_done & (phase == I_WR);
  assign addr_hit = shreg[7:1] == DEV_ADDR;

  // Unmapped offsets read as zero
  assign rd_data =
    (ptr == OFS_PIN_CFG) ? {6'h00, indicator_function_sel} :
    (ptr == OFS_SWITCH_CFG) ? {4'h0, overcurrent_trip_sel, 2'h0} :
    (ptr == OFS_VOUT) ? {1'b0, backup_vout_code} :
    (ptr == OFS_CTRL) ? {1'b0, ctrl} :
    (ptr == OFS_STATUS) ? {5'h00, stopped, state == ST_BACKUP, backup_not_good} :
    8'h00;

  // Clock stretching is not supported; SDA changes only after SCL falls
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase <= I_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      txb <= 8'h00;
      ptr <= 8'h00;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      phase <= I_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      phase <= I_IDLE;
      sda_oe <= 1'b0;
    end else if (phase != I_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt != BYTE_BITS) begin
          shreg <= {shreg[6:0], sda};
          bit_cnt <= bit_cnt + 4'h1;
        end else begin
          bit_cnt <= 4'h0;
          if (phase == I_RD && sda) begin
            phase <= I_IDLE; // Master ended the read
          end
        end
      end else if (byte_done) begin
        sda_oe <= 1'b0;
        unique case (phase)
          I_ADDR: begin
            sda_oe <= addr_hit;
            phase <= !addr_hit ? I_IDLE : (shreg[0] ? I_RD : I_PTR);
          end
          I_PTR: begin
            ptr <= shreg;
            sda_oe <= 1'b1;
            phase <= I_WR;
          end
          I_WR: begin
            ptr <= ptr + 8'h01;
            sda_oe <= 1'b1;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        if (phase == I_RD && bit_cnt == 4'h0) begin
          sda_oe <= ~rd_data[7];
          txb <= {rd_data[6:0], 1'b0};
          ptr <= ptr + 8'h01;
        end else if (phase == I_RD) begin
          sda_oe <= ~txb[7];
          txb <= {txb[6:0], 1'b0};
        end else begin
          sda_oe <= 1'b0;
        end
      end
    end
  end

  // Configuration writes; code 10 never lands in the function field
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      indicator_function_sel <= FN_RESET;
      overcurrent_trip_sel <= OC_RESET;
      backup_vout_code <= VOUT_RESET;
      ctrl <= CTRL_RESET;
    end else if (wr_en) begin
      if (ptr == OFS_PIN_CFG && shreg[FN_LSB +: 2] != FN_INVALID) begin
        indicator_function_sel <= shreg[FN_LSB +: 2]; // R3 R7
      end
      if (ptr == OFS_SWITCH_CFG) begin
        overcurrent_trip_sel <= shreg[OC_LSB +: 2];
      end
      if (ptr == OFS_VOUT) begin
        backup_vout_code <= shreg[6:0];
      end
      if (ptr == OFS_CTRL) begin
        ctrl <= shreg[6:0];
      end
    end
  end

  // Protection decisions
  logic vin_ok, switch_trip, in_backup, uv_hit, stop_now;
  assign vin_ok = vin_low_ok & vin_high_ok;
  assign switch_trip = sec_oc | protect | ~vin_ok; // R1 R18
  assign in_backup = state == ST_BACKUP;
  assign uv_hit = in_backup & out_uv;
  assign stop_now = in_backup & (~str_lock_ok | out_ov | sw_oc | (out_uv & ~backup_not_good_mask)); // R11 R17

  // Operating state: input fed, backup, or held in reset
  bmp_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_NORMAL: begin
        if (switch_trip) begin
          next_state = backup_converter_allow ? ST_BACKUP : ST_POR; // R8
        end
      end
      ST_BACKUP: begin
        if (uv_hit && !backup_not_good_mask) begin
          next_state = ST_POR; // R13
        end
      end
      ST_POR: begin
        if (vin_ok && !sec_oc && !protect) begin
          next_state = ST_NORMAL;
        end
      end
    endcase
  end

  // Status write-one-to-clear; a new undervoltage wins over the clear
  logic status_clear;
  assign status_clear = wr_en & (ptr == OFS_STATUS) & shreg[STAT_NOT_GOOD];
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= ST_POR;
      backup_not_good <= 1'b0;
      stopped <= 1'b0;
    end else begin
      state <= next_state;
      if (uv_hit) begin
        backup_not_good <= 1'b1; // R13
      end else if (status_clear) begin
        backup_not_good <= 1'b0;
      end
      stopped <= in_backup & (stopped | stop_now); // R11
    end
  end

  // Storage regulation flag for the indicator
  logic storage_good;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      storage_good <= 1'b0;
    end else if (str_low95) begin
      storage_good <= 1'b0; // R5
    end else if (str_reg) begin
      storage_good <= 1'b1;
    end
  end

  // Indicator pull-down per function
  logic next_pin_low;
  assign next_pin_low =
    (indicator_function_sel == FN_BACKUP) ? in_backup : // R4
    (indicator_function_sel == FN_STORAGE) ? ~storage_good : // R5
    (indicator_function_sel == FN_VIN_VALID) ? (~vin_ok | in_backup) : // R6
    1'b1;

  // Analog settings derived from register codes
  logic [7:0] target;
  assign target = vout_target(backup_vout_code); // R10

  // Registered outputs; the converter is gated one cycle after a fault
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      input_switch_on <= 1'b0;
      backup_converter_en <= 1'b0;
      full_duty <= 1'b0;
      discharge_sink_on <= 1'b0;
      loss_indicator_pin_out <= 1'b0;
      loss_indicator_pin_oe <= 1'b0;
      sda_out <= 1'b0;
      oc_trip_level <= OC_LVL0;
      vout_target_level <= VOUT_BASE;
      uv_level <= 8'h00;
      ov_level <= 8'h00;
      current_limit_value <= CLIM_BASE;
    end else begin
      input_switch_on <= (state == ST_NORMAL) & ~switch_trip; // R1 R18
      backup_converter_en <= in_backup & backup_converter_allow & ~stopped & ~stop_now; // R8 R11 R17
      full_duty <= in_backup & backup_not_good_mask & out_uv & str_below_out; // R14
      discharge_sink_on <= discharge_enable; // R9
      loss_indicator_pin_out <= 1'b0; // R19
      loss_indicator_pin_oe <= next_pin_low; // R19
      sda_out <= 1'b0;
      oc_trip_level <= oc_level(overcurrent_trip_sel); // R2
      vout_target_level <= target;
      uv_level <= pct_of(target, backup_uv_sel ? UV_PCT_HI : UV_PCT_LO); // R12
      ov_level <= pct_of(target, OV_PCT); // R15
      current_limit_value <= CLIM_BASE + {1'b0, backup_current_limit_code}; // R16
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_trip_at_normal;
    state == ST_NORMAL && switch_trip;
  endsequence
  sequence s_entry_forced_off;
    s_trip_at_normal ##0 !backup_converter_allow;
  endsequence

  chk_oc_opens_switch: assert property (state == ST_NORMAL && sec_oc |=> !input_switch_on && state != ST_NORMAL) // R1
    else $error("secondary overcurrent did not open the switch");
  chk_oc_level_map: assert property (overcurrent_trip_sel == 2'h2 |=> oc_trip_level == OC_LVL2) // R2
    else $error("trip level mismatch");
  chk_fn_no_invalid: assert property (indicator_function_sel != FN_INVALID) // R7
    else $error("invalid indicator function stored");
  chk_backup_pulls_low: assert property (indicator_function_sel == FN_BACKUP && in_backup |=> loss_indicator_pin_oe) // R4
    else $error("indicator not low in backup");
  chk_storage_drop: assert property (indicator_function_sel == FN_STORAGE && str_low95
    ##1 indicator_function_sel == FN_STORAGE |=> loss_indicator_pin_oe) // R5
    else $error("indicator not low on storage drop");
  chk_vin_window: assert property (indicator_function_sel == FN_VIN_VALID && !vin_ok |=> loss_indicator_pin_oe) // R6
    else $error("indicator released outside input window");
  chk_forced_off_por: assert property (s_entry_forced_off |=> state == ST_POR ##1 !backup_converter_en) // R8
    else $error("forced off entry did not reach reset state");
  chk_discharge_follow: assert property ($rose(discharge_enable) |=> discharge_sink_on) // R9
    else $error("discharge sink not on");
  chk_vout_clamp: assert property (vout_target_level <= VOUT_MAX) // R10
    else $error("output target above clamp");
  chk_switch_oc_stop: assert property (in_backup && sw_oc |=> !backup_converter_en [*2]) // R17 R11
    else $error("converter kept running after switch overcurrent");
  chk_uv_to_por: assert property (uv_hit && !backup_not_good_mask |=> state == ST_POR && backup_not_good) // R13
    else $error("undervoltage did not reach reset state");
  chk_masked_full_duty: assert property (uv_hit && backup_not_good_mask && str_below_out |=> full_duty && state == ST_BACKUP) // R14
    else $error("masked undervoltage did not go full duty");
  chk_ov_above_target: assert property ($past(nrst) |-> ov_level >= vout_target_level) // R15
    else $error("overvoltage level below target");
  chk_open_drain: assert property (!loss_indicator_pin_out && !sda_out) // R19
    else $error("open drain pin driven high");

endmodule
`default_nettype wire

// file: dv/bmp_host_model.sv
/*
  Host side model: I2C master for the register port, plus the pull-ups on
  SDA and on the power-loss indicator pin. Assumes one transfer at a time
  and a device that never stretches SCL.
*/
`timescale 1ns/1ps
`default_nettype none
module bmp_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic clock,
  input wire logic sda_oe,
  input wire logic pin_oe,
  output logic scl,
  output logic sda,
  output logic pin_level
);
  logic sda_rel;
  // Open-drain lines resolve against pull-ups, so a released line reads 1
  assign sda = sda_rel & ~sda_oe;
  assign pin_level = ~pin_oe;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Five clocks a step keeps each SCL half period above the four-clock floor
  task automatic tick();
    repeat (5) @(posedge clock);
    #1;
  endtask
  // SDA moves only while SCL is low; sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    tick();
    scl = 1'b1;
    tick();
    r = sda;
    scl = 1'b0;
    tick();
  endtask
  // Start and repeated start share one shape
  task automatic start();
    sda_rel = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_rel = 1'b0;
    tick();
    scl = 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_rel = 1'b1;
    tick();
  endtask
  // Ninth bit is always released: it reads the ACK, or sends NACK on reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, nak);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    xfer({DEV_ADDR, 1'b0}, q, n0);
    xfer(ofs, q, n1);
    xfer(d, q, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] q, output logic nak);
    logic n0, n1, n2, nl;
    start();
    xfer({DEV_ADDR, 1'b0}, q, n0);
    xfer(ofs, q, n1);
    start();
    xfer({DEV_ADDR, 1'b1}, q, n2);
    xfer(8'hff, q, nl);
    stop();
    nak = n0 | n1 | n2;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
/*
  Self-checking bench for the backup mode protection control block.
  Assumes the host model owns the register port and the pin pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bmp_pkg::*;
  logic clock, nrst, scl_in, sda_in, sda_out, sda_oe, pin_level, uv7;
  logic vin_above_low, vin_below_high, input_protect_trip, secondary_oc_hit;
  logic storage_in_reg, storage_below_95, storage_above_lockout, storage_below_out;
  logic backup_out_below_uv, backup_out_above_ov, backup_switch_oc;
  logic input_switch_on, backup_converter_en, full_duty, discharge_sink_on;
  logic loss_indicator_pin_out, loss_indicator_pin_oe;
  logic [1:0] overcurrent_trip_sel;
  logic [2:0] cl;
  logic [3:0] current_limit_value;
  logic [6:0] code;
  logic [7:0] oc_trip_level, vout_target_level, uv_level, ov_level, q, tgt;
  int n_fail, compares;
  bmp_backup_control DUT (.clock, .nrst, .scl_in, .sda_in, .sda_out, .sda_oe,
    .vin_above_low, .vin_below_high, .input_protect_trip, .secondary_oc_hit,
    .storage_in_reg, .storage_below_95, .storage_above_lockout,
    .backup_out_below_uv, .backup_out_above_ov, .backup_switch_oc, .storage_below_out,
    .input_switch_on, .backup_converter_en, .full_duty, .discharge_sink_on,
    .loss_indicator_pin_out, .loss_indicator_pin_oe, .overcurrent_trip_sel,
    .oc_trip_level, .vout_target_level, .uv_level, .ov_level, .current_limit_value);
  bmp_host_model host (.clock, .sda_oe, .pin_oe(loss_indicator_pin_oe), .scl(scl_in),
    .sda(sda_in), .pin_level);
  // 25 MHz
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic logic [7:0] exp_tgt(input logic [6:0] c);
    return ((VOUT_BASE + 8'(c)) > VOUT_MAX) ? VOUT_MAX : VOUT_BASE + 8'(c);
  endfunction
  // Truncated percentage, widened so the product cannot wrap
  function automatic logic [7:0] pct(input logic [7:0] t, input logic [6:0] p);
    return 8'((16'(t) * 16'(p)) / 16'h64);
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic done(input string name);
    $display("test %s ended, n_fail %0d", name, n_fail);
  endtask
  task automatic wreg(input logic [7:0] ofs, input logic [7:0] d);
    logic nak;
    host.wr(ofs, d, nak);
    chk("write ack", 8'h00, {7'h0, nak});
  endtask
  task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp, input string what);
    logic nak;
    host.rd(ofs, q, nak);
    chk(what, exp, q);
  endtask
  // Bounded wait on the input path; running out ends the run
  task automatic wait_sw(input logic v);
    int k;
    k = 0;
    while (input_switch_on !== v && k < 80) begin
      step(1);
      k++;
    end
    if (input_switch_on !== v) begin
      n_fail++;
      $display("mismatch switch wait expected %b seen %b", v, input_switch_on);
      close_out();
    end
  endtask
  // Reset also returns every comparator to idle, with the input out of window and storage above lockout
  task automatic reset_dut(input int n);
    nrst = 1'b0;
    {vin_above_low, vin_below_high, input_protect_trip, secondary_oc_hit} = 4'h0;
    {storage_in_reg, storage_below_95, storage_below_out} = 3'h0;
    {backup_out_below_uv, backup_out_above_ov, backup_switch_oc} = 3'h0;
    storage_above_lockout = 1'b1;
    step(n);
    nrst = 1'b1;
    step(4);
  endtask
  task automatic trip_in(input logic by_oc);
    vin_above_low = 1'b1;
    vin_below_high = 1'b1;
    wait_sw(1'b1);
    secondary_oc_hit = by_oc;
    input_protect_trip = ~by_oc;
    wait_sw(1'b0);
    step(4);
  endtask
  initial begin
    repeat (90000) @(posedge clock);
    n_fail++;
    $display("mismatch run length expected end seen hang");
    close_out();
  end
  initial begin
    n_fail = 0;
    compares = 0;
    void'($urandom(26941));
    reset_dut(12);
    chk("oc level", 8'h41, oc_trip_level);
    chk("target", 8'h19, vout_target_level);
    chk("limit", 8'h03, {4'h0, current_limit_value});
    rchk(OFS_CTRL, 8'h01, "control");
    wreg(8'h40, 8'h5a);
    rchk(8'h40, 8'h00, "unmapped");
    wreg(OFS_PIN_CFG, 8'h01);
    wreg(OFS_PIN_CFG, 8'h02);
    rchk(OFS_PIN_CFG, 8'h01, "pin cfg");
    wreg(OFS_PIN_CFG, 8'h03);
    rchk(OFS_PIN_CFG, 8'h03, "pin cfg");
    done("registers");
    for (int s = 0; s < 4; s++) begin
      wreg(OFS_SWITCH_CFG, 8'(s << 2));
      rchk(OFS_SWITCH_CFG, 8'(s << 2), "oc cfg");
      chk("oc sel", 8'(s), {6'h0, overcurrent_trip_sel});
      chk("oc level", 8'h41 + 8'(s) * 8'h28, oc_trip_level);
    end
    // Random codes, with the exact top and the clamped region first
    for (int i = 0; i < 8; i++) begin
      code = (i == 0) ? 7'h6b : (i == 1) ? 7'h7f : (i == 2) ? 7'h00 : 7'($urandom);
      cl = (i < 2) ? {3{i[0]}} : 3'($urandom);
      uv7 = 1'($urandom);
      wreg(OFS_VOUT, {1'b0, code});
      wreg(OFS_CTRL, {1'b0, cl, 1'b0, uv7, 1'b0, 1'b1});
      step(3);
      tgt = exp_tgt(code);
      chk("target", tgt, vout_target_level);
      chk("ov level", pct(tgt, OV_PCT), ov_level);
      chk("uv level", pct(tgt, uv7 ? UV_PCT_HI : UV_PCT_LO), uv_level);
      chk("limit", {4'h0, CLIM_BASE + 4'(cl)}, {4'h0, current_limit_value});
    end
    done("levels");
    // Storage lockout, overvoltage and switch overcurrent each shut a running converter
    for (int c = 0; c < 3; c++) begin
      reset_dut(2);
      trip_in(c == 0);
      chk("conv run", 8'h01, {7'h0, backup_converter_en});
      chk("pin backup", 8'h00, {7'h0, pin_level});
      chk("pin drive", 8'h00, {7'h0, loss_indicator_pin_out});
      chk("sda drive", 8'h00, {7'h0, sda_out});
      storage_above_lockout = (c != 0);
      backup_out_above_ov = (c == 1);
      backup_switch_oc = (c == 2);
      step(6);
      chk("conv stop", 8'h00, {7'h0, backup_converter_en});
    end
    done("stop causes");
    for (int m = 0; m < 2; m++) begin
      reset_dut(2);
      wreg(OFS_CTRL, 8'h03 | 8'(m << 3));
      chk("sink", 8'h01, {7'h0, discharge_sink_on});
      trip_in(1'b1);
      backup_out_below_uv = 1'b1;
      step(6);
      chk("conv uv", 8'(m), {7'h0, backup_converter_en});
      storage_below_out = 1'b1;
      step(6);
      chk("full duty", 8'(m), {7'h0, full_duty});
      // Masked undervoltage stays in backup, so the backup status bit shows too
      rchk(OFS_STATUS, 8'h01 | 8'(m << 1), "status");
    end
    done("undervoltage");
    reset_dut(2);
    wreg(OFS_CTRL, 8'h00);
    trip_in(1'b1);
    chk("conv forced", 8'h00, {7'h0, backup_converter_en});
    secondary_oc_hit = 1'b0;
    wait_sw(1'b1);
    reset_dut(2);
    wreg(OFS_PIN_CFG, 8'h01);
    step(3);
    chk("pin soft", 8'h00, {7'h0, pin_level});
    storage_in_reg = 1'b1;
    step(6);
    chk("pin reg", 8'h01, {7'h0, pin_level});
    storage_below_95 = 1'b1;
    step(6);
    chk("pin sag", 8'h00, {7'h0, pin_level});
    vin_above_low = 1'b1;
    vin_below_high = 1'b1;
    wreg(OFS_PIN_CFG, 8'h03);
    step(6);
    chk("pin window", 8'h01, {7'h0, pin_level});
    vin_above_low = 1'b0;
    step(6);
    chk("pin low in", 8'h00, {7'h0, pin_level});
    done("indicator");
    close_out();
  end
endmodule
`default_nettype wire

// file: include/bmp_pkg.sv
/*
  Shared constants and types for the backup mode protection control block.
  Assumes analog comparators and the I2C pins are sampled by the design module.
*/
package bmp_pkg;
  // Register offsets on the serial configuration port
  localparam logic [7:0] OFS_PIN_CFG = 8'h26;
  localparam logic [7:0] OFS_SWITCH_CFG = 8'h2c;
  localparam logic [7:0] OFS_VOUT = 8'hcb;
  localparam logic [7:0] OFS_CTRL = 8'hcc;
  localparam logic [7:0] OFS_STATUS = 8'hcd;
  // Field positions
  localparam int FN_LSB = 0;
  localparam int OC_LSB = 2;
  localparam int CTRL_ALLOW = 0;
  localparam int CTRL_DISC = 1;
  localparam int CTRL_UV70 = 2;
  localparam int CTRL_MASK = 3;
  localparam int CTRL_CLIM_LSB = 4;
  localparam int STAT_NOT_GOOD = 0;
  localparam int STAT_BACKUP = 1;
  localparam int STAT_STOPPED = 2;
  // Reset values
  localparam logic [1:0] FN_RESET = 2'h0;
  localparam logic [1:0] OC_RESET = 2'h0;
  localparam logic [6:0] VOUT_RESET = 7'h00;
  localparam logic [6:0] CTRL_RESET = 7'h01;
  localparam logic [12:0] SYNC_RESET = 13'h1800;
  // Indicator functions
  localparam logic [1:0] FN_BACKUP = 2'h0;
  localparam logic [1:0] FN_STORAGE = 2'h1;
  localparam logic [1:0] FN_INVALID = 2'h2;
  localparam logic [1:0] FN_VIN_VALID = 2'h3;
  // Levels: voltages in 100 mV, currents in 100 mA or 1 A units
  localparam logic [7:0] VOUT_BASE = 8'h19;
  localparam logic [7:0] VOUT_MAX = 8'h84;
  localparam logic [7:0] OC_LVL0 = 8'h41;
  localparam logic [7:0] OC_LVL1 = 8'h69;
  localparam logic [7:0] OC_LVL2 = 8'h91;
  localparam logic [7:0] OC_LVL3 = 8'hb9;
  localparam logic [3:0] CLIM_BASE = 4'h3;
  localparam logic [6:0] UV_PCT_LO = 7'h3c;
  localparam logic [6:0] UV_PCT_HI = 7'h46;
  localparam logic [6:0] OV_PCT = 7'h6e;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [1:0] {ST_NORMAL = 2'b00, ST_BACKUP = 2'b01, ST_POR = 2'b11} bmp_state_t;
  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_ADDR = 3'b001, I_PTR = 3'b011, I_WR = 3'b010, I_RD = 3'b110
  } bmp_i2c_t;

  // Output target in 100 mV units, clamped at the top code
  function automatic logic [7:0] vout_target(input logic [6:0] code);
    logic [7:0] sum;
    sum = VOUT_BASE + {1'b0, code};
    return (sum > VOUT_MAX) ? VOUT_MAX : sum;
  endfunction

  // Percentage of a level, truncated
  function automatic logic [7:0] pct_of(input logic [7:0] v, input logic [6:0] p);
    logic [14:0] prod;
    prod = 15'(v) * 15'(p);
    return 8'(prod / 15'(PCT_FULL));
  endfunction

  function automatic logic [7:0] oc_level(input logic [1:0] sel);
    case (sel)
      2'h0: return OC_LVL0;
      2'h1: return OC_LVL1;
      2'h2: return OC_LVL2;
      default: return OC_LVL3;
    endcase
  endfunction
endpackage
